// ==== hdl/sfs_limit_cmp.sv ====
// measurement against high and low thresholds, one-cycle hits
`timescale 1ns/1ps
module sfs_limit_cmp #(
    parameter int W = 12
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic         valid_i,
    input  wire logic [W-1:0] code_i,
    input  wire logic [W-1:0] hi_lim_i,
    input  wire logic [W-1:0] lo_lim_i,
    output logic              hi_o,
    output logic              lo_o
);
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hi_o <= 1'b0;
            lo_o <= 1'b0;
        end else begin
            hi_o <= valid_i && (code_i > hi_lim_i);
            lo_o <= valid_i && (code_i < lo_lim_i);
        end
    end
endmodule // sfs_limit_cmp

// ==== hdl/sfs_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sfs_pin_sync #(
    parameter int           W       = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge mclk_i) begin
            if (rst_i) begin
                s1_q[i]    <= RST_VAL[i];
                s2_q[i]    <= RST_VAL[i];
                s3_q[i]    <= RST_VAL[i];
                level_o[i] <= RST_VAL[i];
            end else begin
                s1_q[i] <= pin_i[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                // a change counts only once two late stages agree
                if (s2_q[i] == s3_q[i]) begin
                    level_o[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // sfs_pin_sync

// ==== hdl/sfs_pkg.sv ====
// constants for the supply fault status registers
package sfs_pkg;
    // command codes
    localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUMMARY     = 8'h79;
    localparam logic [7:0] CMD_OUT_VOLT    = 8'h7a;
    localparam logic [7:0] CMD_OUT_CURR    = 8'h7b;
    localparam logic [7:0] CMD_IN_SUPPLY   = 8'h7c;
    localparam logic [7:0] CMD_VIN_HI_LIM  = 8'h57;
    localparam logic [7:0] CMD_VIN_LO_LIM  = 8'h58;
    localparam logic [7:0] CMD_CUR_LIM     = 8'he0;
    localparam logic [7:0] CMD_OUTPUT_SENSE_PIN_HI_LIM = 8'he1;
    localparam logic [7:0] CMD_OUTPUT_SENSE_PIN_LO_LIM = 8'he2;
    localparam logic [7:0] CMD_CLEAR       = 8'he3;
    // measurement width and threshold reset values
    localparam int         ADC_W           = 12;
    localparam logic [11:0] LIM_HIGH_RST   = 12'h0fff;
    localparam logic [11:0] LIM_LOW_RST    = 12'h0000;
    // summary word bits
    localparam int SW_OUT_VOLT  = 15;
    localparam int SW_OUT_CURR  = 14;
    localparam int SW_IN_SUPPLY = 13;
    localparam int SW_VENDOR    = 12;
    localparam int SW_PGOOD_N   = 11;
    // output voltage / current / input supply byte bits
    localparam int VO_HIGH = 6;
    localparam int VO_LOW  = 5;
    localparam int IO_TRIP = 7;
    localparam int IO_WARN = 5;
    localparam int IN_HF   = 7;
    localparam int IN_HW   = 6;
    localparam int IN_LW   = 5;
    localparam int IN_LF   = 4;
    // status byte bits
    localparam int SB_OFF  = 6;
    localparam int SB_TRIP = 4;
    localparam int SB_LF   = 3;
    localparam int SB_CML  = 1;
    localparam int SB_NOTA = 0;
    // latched flag vector indices
    localparam int F_OH   = 0;
    localparam int F_OL   = 1;
    localparam int F_TRIP = 2;
    localparam int F_CW   = 3;
    localparam int F_IHF  = 4;
    localparam int F_IHW  = 5;
    localparam int F_ILW  = 6;
    localparam int F_ILF  = 7;
    localparam int F_CML  = 8;
    localparam int F_N    = 9;
    // pin synchroniser lanes and reset levels (foldback idles good)
    localparam int         PIN_HI = 0;
    localparam int         PIN_LO = 1;
    localparam int         PIN_FB = 2;
    localparam logic [2:0] PIN_RST = 3'h4;
endpackage

// ==== hdl/sfs_status_regs.sv ====
// status word and status bytes with their latches and command port
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Function
// RULE1: summary word read at 0x79, resets zero
// RULE2: bit15 set when voltage byte nonzero
// RULE3: bit14 set when current byte nonzero
// RULE4: bit13 set when input byte nonzero
// RULE5: bit12 set when vendor byte nonzero
// RULE6: bit11 is inverse of power good
// RULE7: summary bits 10..8 read zero
// RULE8: low summary byte equals status byte
// RULE9: voltage byte at 0x7A, variant only
// RULE10: voltage bit6 latches output high warning
// RULE11: voltage bit5 latches output low warning
// RULE12: voltage and current bits 4..0 zero
// RULE13: current byte at 0x7B, resets zero
// RULE14: current bit7 latches current trip fault
// RULE15: current bit5 latches current high warning
// RULE16: input byte at 0x7C, resets zero
// RULE17: input bit7 latches high limit pin
// RULE18: input bit6 latches input high warning
// RULE19: input bit5 latches input low warning
// RULE20: input bit4 latches low limit pin
// RULE21: input bits 3..0 read zero
// RULE22: current warning compares 12-bit code, threshold
// RULE23: input high threshold resets to 0x0FFF
// RULE24: latched bits hold until clear or reset
module sfs_status_regs #(
    parameter bit HAS_OUT_SENSE = 1'b1
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_write_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [15:0] cmd_wdata_i,
    output logic             rsp_valid_o,
    output logic [15:0]      rsp_data_o,
    output logic             rsp_err_o,
    input  wire logic        high_limit_input_pin_i,
    input  wire logic        low_limit_input_pin_i,
    input  wire logic        foldback_sense_pin_i,
    input  wire logic        current_trip_fault_i,
    input  wire logic        gate_off_i,
    input  wire logic [7:0]  vendor_flags_byte_i,
    input  wire logic        vin_valid_i,
    input  wire logic [11:0] vin_code_i,
    input  wire logic        output_sense_pin_valid_i,
    input  wire logic [11:0] output_sense_pin_code_i,
    input  wire logic        iout_valid_i,
    input  wire logic [11:0] iout_code_i,
    output logic             supply_good_pin_o
);
    localparam int AW = sfs_pkg::ADC_W;

    logic [2:0]          pin_lvl;
    logic [sfs_pkg::F_N-1:0] flags_q;
    logic [sfs_pkg::F_N-1:0] flags_set;
    logic [AW-1:0]       vin_hi_lim_q;
    logic [AW-1:0]       vin_lo_lim_q;
    logic [AW-1:0]       cur_lim_q;
    logic [AW-1:0]       output_sense_pin_hi_lim_q;
    logic [AW-1:0]       output_sense_pin_lo_lim_q;
    logic                vin_hi_hit;
    logic                vin_lo_hit;
    logic                output_sense_pin_hi_hit;
    logic                output_sense_pin_lo_hit;
    logic                cur_hi_hit;
    logic [7:0]          output_sense_pin_byte;
    logic [7:0]          iout_byte;
    logic [7:0]          input_byte;
    logic [7:0]          status_byte;
    logic [15:0]         summary_word;

    ////////////////////////////////////////////////////////////////////////////
    // pins and threshold comparisons

    sfs_pin_sync #(
        .W       (3),
        .RST_VAL (sfs_pkg::PIN_RST)
    ) u_pins (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .pin_i   ({foldback_sense_pin_i, low_limit_input_pin_i, high_limit_input_pin_i}),
        .level_o (pin_lvl)
    );

    sfs_limit_cmp #(.W(AW)) u_vin (
        .mclk_i   (mclk_i),
        .rst_i    (rst_i),
        .valid_i  (vin_valid_i),
        .code_i   (vin_code_i),
        .hi_lim_i (vin_hi_lim_q),
        .lo_lim_i (vin_lo_lim_q),
        .hi_o     (vin_hi_hit),
        .lo_o     (vin_lo_hit)
    );

    sfs_limit_cmp #(.W(AW)) u_output_sense_pin (
        .mclk_i   (mclk_i),
        .rst_i    (rst_i),
        .valid_i  (output_sense_pin_valid_i),
        .code_i   (output_sense_pin_code_i),
        .hi_lim_i (output_sense_pin_hi_lim_q),
        .lo_lim_i (output_sense_pin_lo_lim_q),
        .hi_o     (output_sense_pin_hi_hit),
        .lo_o     (output_sense_pin_lo_hit)
    );

    // only the high side is used; low limit held at zero never hits
    sfs_limit_cmp #(.W(AW)) u_cur (
        .mclk_i   (mclk_i),
        .rst_i    (rst_i),
        .valid_i  (iout_valid_i),
        .code_i   (iout_code_i),
        .hi_lim_i (cur_lim_q),
        .lo_lim_i (sfs_pkg::LIM_LOW_RST),
        .hi_o     (cur_hi_hit),
        .lo_o     ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // command decode

    wire is_rd     = cmd_valid_i && !cmd_write_i;
    wire is_wr     = cmd_valid_i && cmd_write_i;
    wire rd_sb     = is_rd && (cmd_code_i == sfs_pkg::CMD_STATUS_BYTE);
    wire rd_sum    = is_rd && (cmd_code_i == sfs_pkg::CMD_SUMMARY);
    wire rd_vo     = is_rd && (cmd_code_i == sfs_pkg::CMD_OUT_VOLT) && HAS_OUT_SENSE; // [RULE9]
    wire rd_io     = is_rd && (cmd_code_i == sfs_pkg::CMD_OUT_CURR);
    wire rd_in     = is_rd && (cmd_code_i == sfs_pkg::CMD_IN_SUPPLY);
    wire sel_vinh  = cmd_code_i == sfs_pkg::CMD_VIN_HI_LIM;
    wire sel_vinl  = cmd_code_i == sfs_pkg::CMD_VIN_LO_LIM;
    wire sel_cur   = cmd_code_i == sfs_pkg::CMD_CUR_LIM;
    wire sel_vouth = (cmd_code_i == sfs_pkg::CMD_OUTPUT_SENSE_PIN_HI_LIM) && HAS_OUT_SENSE;
    wire sel_voutl = (cmd_code_i == sfs_pkg::CMD_OUTPUT_SENSE_PIN_LO_LIM) && HAS_OUT_SENSE;
    wire sel_lim   = sel_vinh || sel_vinl || sel_cur || sel_vouth || sel_voutl;
    wire clr_cmd   = is_wr && (cmd_code_i == sfs_pkg::CMD_CLEAR);
    wire rd_ok     = rd_sb || rd_sum || rd_vo || rd_io || rd_in || (is_rd && sel_lim);
    wire wr_ok     = clr_cmd || (is_wr && sel_lim);
    wire cmd_bad   = cmd_valid_i && !(rd_ok || wr_ok);
    wire fb_ok     = pin_lvl[sfs_pkg::PIN_FB];

    wire [AW-1:0] lim_rd = sel_vinh  ? vin_hi_lim_q  :
                           sel_vinl  ? vin_lo_lim_q  :
                           sel_cur   ? cur_lim_q     :
                           sel_vouth ? output_sense_pin_hi_lim_q : output_sense_pin_lo_lim_q;

    wire [15:0] rd_data = rd_sum ? summary_word        :
                          rd_sb  ? {8'h00, status_byte} :
                          rd_vo  ? {8'h00, output_sense_pin_byte}   :
                          rd_io  ? {8'h00, iout_byte}   :
                          rd_in  ? {8'h00, input_byte}  :
                          rd_ok  ? {4'h0, lim_rd}       : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // latched flags: set wins over clear

    always_comb begin
        flags_set                   = '0;
        flags_set[sfs_pkg::F_OH]    = output_sense_pin_hi_hit && HAS_OUT_SENSE;          // [RULE10]
        flags_set[sfs_pkg::F_OL]    = output_sense_pin_lo_hit && HAS_OUT_SENSE;          // [RULE11]
        flags_set[sfs_pkg::F_TRIP]  = current_trip_fault_i;                  // [RULE14]
        flags_set[sfs_pkg::F_CW]    = cur_hi_hit;                            // [RULE15] [RULE22]
        flags_set[sfs_pkg::F_IHF]   = pin_lvl[sfs_pkg::PIN_HI];              // [RULE17]
        flags_set[sfs_pkg::F_IHW]   = vin_hi_hit;                            // [RULE18] [RULE23]
        flags_set[sfs_pkg::F_ILW]   = vin_lo_hit;                            // [RULE19]
        flags_set[sfs_pkg::F_ILF]   = pin_lvl[sfs_pkg::PIN_LO];              // [RULE20]
        flags_set[sfs_pkg::F_CML]   = cmd_bad;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_set | (flags_q & ~{sfs_pkg::F_N{clr_cmd}});    // [RULE24]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // thresholds, written as words; upper nibble ignored

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            vin_hi_lim_q  <= sfs_pkg::LIM_HIGH_RST;                           // [RULE23]
            vin_lo_lim_q  <= sfs_pkg::LIM_LOW_RST;
            cur_lim_q     <= sfs_pkg::LIM_HIGH_RST;
            output_sense_pin_hi_lim_q <= sfs_pkg::LIM_HIGH_RST;
            output_sense_pin_lo_lim_q <= sfs_pkg::LIM_LOW_RST;
        end else if (is_wr) begin
            if (sel_vinh)  vin_hi_lim_q  <= cmd_wdata_i[AW-1:0];
            if (sel_vinl)  vin_lo_lim_q  <= cmd_wdata_i[AW-1:0];
            if (sel_cur)   cur_lim_q     <= cmd_wdata_i[AW-1:0];              // [RULE22]
            if (sel_vouth) output_sense_pin_hi_lim_q <= cmd_wdata_i[AW-1:0];
            if (sel_voutl) output_sense_pin_lo_lim_q <= cmd_wdata_i[AW-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // byte and word assembly; reserved bits stay zero

    always_comb begin
        output_sense_pin_byte                   = '0;                                    // [RULE12]
        output_sense_pin_byte[sfs_pkg::VO_HIGH] = flags_q[sfs_pkg::F_OH];
        output_sense_pin_byte[sfs_pkg::VO_LOW]  = flags_q[sfs_pkg::F_OL];
        iout_byte                   = '0;                                    // [RULE12]
        iout_byte[sfs_pkg::IO_TRIP] = flags_q[sfs_pkg::F_TRIP];
        iout_byte[sfs_pkg::IO_WARN] = flags_q[sfs_pkg::F_CW];
        input_byte                  = '0;                                    // [RULE21]
        input_byte[sfs_pkg::IN_HF]  = flags_q[sfs_pkg::F_IHF];
        input_byte[sfs_pkg::IN_HW]  = flags_q[sfs_pkg::F_IHW];
        input_byte[sfs_pkg::IN_LW]  = flags_q[sfs_pkg::F_ILW];
        input_byte[sfs_pkg::IN_LF]  = flags_q[sfs_pkg::F_ILF];
        status_byte                 = '0;
        status_byte[sfs_pkg::SB_OFF]  = gate_off_i;
        status_byte[sfs_pkg::SB_TRIP] = flags_q[sfs_pkg::F_TRIP];
        status_byte[sfs_pkg::SB_LF]   = flags_q[sfs_pkg::F_ILF];
        status_byte[sfs_pkg::SB_CML]  = flags_q[sfs_pkg::F_CML];
        status_byte[sfs_pkg::SB_NOTA] = |{output_sense_pin_byte, iout_byte, input_byte, vendor_flags_byte_i};
        summary_word                = '0;                                    // [RULE7]
        summary_word[7:0]           = status_byte;                           // [RULE8]
        summary_word[sfs_pkg::SW_OUT_VOLT]  = |output_sense_pin_byte;                    // [RULE2]
        summary_word[sfs_pkg::SW_OUT_CURR]  = |iout_byte;                    // [RULE3]
        summary_word[sfs_pkg::SW_IN_SUPPLY] = |input_byte;                   // [RULE4]
        summary_word[sfs_pkg::SW_VENDOR]    = |vendor_flags_byte_i;          // [RULE5]
        summary_word[sfs_pkg::SW_PGOOD_N]   = !fb_ok;                        // [RULE6]
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer registers: one cycle after the request

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rsp_valid_o       <= 1'b0;
            rsp_data_o        <= 16'h0000;                                   // [RULE1]
            rsp_err_o         <= 1'b0;
            supply_good_pin_o <= 1'b1;
        end else begin
            rsp_valid_o       <= cmd_valid_i;
            rsp_data_o        <= rd_data;                                    // [RULE1] [RULE13] [RULE16]
            rsp_err_o         <= cmd_bad;
            supply_good_pin_o <= fb_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_reset_clear;
        @(posedge mclk_i) rst_i |=> (flags_q == '0) && !rsp_valid_o && (rsp_data_o == 16'h0000);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not cleared by reset"); // [RULE1]

    property p_sum_output_sense_pin;
        @(posedge mclk_i) disable iff (rst_i) rd_sum |=> rsp_data_o[15] == $past(|output_sense_pin_byte);
    endproperty
    a_sum_output_sense_pin: assert property (p_sum_output_sense_pin) else $error("summary bit 15 wrong"); // [RULE2]

    property p_sum_iout;
        @(posedge mclk_i) disable iff (rst_i) rd_sum |=> rsp_data_o[14] == $past(|iout_byte);
    endproperty
    a_sum_iout: assert property (p_sum_iout) else $error("summary bit 14 wrong"); // [RULE3]

    property p_sum_input;
        @(posedge mclk_i) disable iff (rst_i) rd_sum |=> rsp_data_o[13] == $past(|input_byte);
    endproperty
    a_sum_input: assert property (p_sum_input) else $error("summary bit 13 wrong"); // [RULE4]

    property p_sum_vendor;
        @(posedge mclk_i) disable iff (rst_i) rd_sum |=> rsp_data_o[12] == $past(|vendor_flags_byte_i);
    endproperty
    a_sum_vendor: assert property (p_sum_vendor) else $error("summary bit 12 wrong"); // [RULE5]

    property p_sum_pgood;
        @(posedge mclk_i) disable iff (rst_i) rd_sum |=> rsp_data_o[11] != supply_good_pin_o;
    endproperty
    a_sum_pgood: assert property (p_sum_pgood) else $error("summary bit 11 not inverse of power good"); // [RULE6]

    property p_sum_low;
        @(posedge mclk_i) disable iff (rst_i)
            rd_sum |=> (rsp_data_o[10:8] == 3'h0) && (rsp_data_o[7:0] == $past(status_byte));
    endproperty
    a_sum_low: assert property (p_sum_low) else $error("summary low byte or reserved bits wrong"); // [RULE8]

    property p_trip_latch;
        @(posedge mclk_i) disable iff (rst_i) current_trip_fault_i |=> flags_q[sfs_pkg::F_TRIP];
    endproperty
    a_trip_latch: assert property (p_trip_latch) else $error("current trip not latched"); // [RULE14]

    property p_cur_warn;
        @(posedge mclk_i) disable iff (rst_i)
            (iout_valid_i && (iout_code_i > cur_lim_q)) |-> ##2 flags_q[sfs_pkg::F_CW];
    endproperty
    a_cur_warn: assert property (p_cur_warn) else $error("current warning not latched"); // [RULE15]

    property p_hold;
        @(posedge mclk_i) disable iff (rst_i)
            !clr_cmd |=> ((flags_q & $past(flags_q)) == $past(flags_q));
    endproperty
    a_hold: assert property (p_hold) else $error("latched flag dropped without clear"); // [RULE24]

    property p_io_rsv;
        @(posedge mclk_i) disable iff (rst_i)
            (rd_io || rd_vo) |=> rsp_data_o[4:0] == 5'h00;
    endproperty
    a_io_rsv: assert property (p_io_rsv) else $error("reserved status bits not zero"); // [RULE12]
endmodule // sfs_status_regs

// ==== test/sfs_host_model.sv ====
// host model issuing requests on the status command port
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module sfs_host_model (
    input  wire logic        mclk_i,
    input  wire logic        rsp_valid_i,
    input  wire logic [15:0] rsp_data_i,
    input  wire logic        rsp_err_i,
    output logic             cmd_valid_o,
    output logic             cmd_write_o,
    output logic [7:0]       cmd_code_o,
    output logic [15:0]      cmd_wdata_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o  = 8'h00;
        cmd_wdata_o = 16'h0000;
    end
    // one request, answer taken one edge later; idle lines carry the inverse
    // so a stale code or data value can never pass for a live one
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] wd, output logic [17:0] r);
        @(posedge mclk_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= w;
        cmd_code_o  <= c;
        cmd_wdata_o <= wd;
        @(posedge mclk_i);
        cmd_valid_o <= 1'b0;
        cmd_write_o <= ~w;
        cmd_code_o  <= ~c;
        cmd_wdata_o <= ~wd;
        #1;
        r = {rsp_valid_i, rsp_err_i, rsp_data_i};
    endtask
endmodule // sfs_host_model

// ==== test/sfs_status_regs_test.sv ====
// self-checking bench for the status word and status bytes
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module sfs_status_regs_test;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cmd_valid_i, cmd_write_i, rsp_valid_o, rsp_err_o, supply_good_pin_o;
    logic [7:0]  cmd_code_i;
    logic [15:0] cmd_wdata_i, rsp_data_o, rsp_data_b;
    logic        rsp_valid_b, rsp_err_b;
    logic        high_limit_input_pin_i = 1'b0;
    logic        low_limit_input_pin_i = 1'b0;
    logic        foldback_sense_pin_i = 1'b1;
    logic        current_trip_fault_i = 1'b0;
    logic        gate_off_i = 1'b0;
    logic [7:0]  vendor_flags_byte_i = 8'h00;
    logic        vin_valid_i = 1'b0, output_sense_pin_valid_i = 1'b0, iout_valid_i = 1'b0;
    logic [11:0] vin_code_i = 12'h000, output_sense_pin_code_i = 12'h000, iout_code_i = 12'h000;
    logic [17:0] r;
    int          mismatches = 0;
    int          samples_checked = 0;

    always #2.5 mclk_i = ~mclk_i;

    sfs_status_regs u_sfs_status_regs (.mclk_i, .rst_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i,
        .cmd_wdata_i, .rsp_valid_o, .rsp_data_o, .rsp_err_o, .high_limit_input_pin_i,
        .low_limit_input_pin_i, .foldback_sense_pin_i, .current_trip_fault_i, .gate_off_i,
        .vendor_flags_byte_i, .vin_valid_i, .vin_code_i, .output_sense_pin_valid_i, .output_sense_pin_code_i,
        .iout_valid_i, .iout_code_i, .supply_good_pin_o);
    // variant without output sense shares every input
    sfs_status_regs #(.HAS_OUT_SENSE(1'b0)) u_sfs_status_regs_b (.mclk_i, .rst_i, .cmd_valid_i,
        .cmd_write_i, .cmd_code_i, .cmd_wdata_i, .rsp_valid_o(rsp_valid_b), .rsp_data_o(rsp_data_b),
        .rsp_err_o(rsp_err_b), .high_limit_input_pin_i, .low_limit_input_pin_i, .foldback_sense_pin_i,
        .current_trip_fault_i, .gate_off_i, .vendor_flags_byte_i, .vin_valid_i, .vin_code_i,
        .output_sense_pin_valid_i, .output_sense_pin_code_i, .iout_valid_i, .iout_code_i, .supply_good_pin_o());
    sfs_host_model u_sfs_host_model (.mclk_i, .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
        .rsp_err_i(rsp_err_o), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
        .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [17:0] s, input logic [17:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // answer is {valid, error, data}
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        u_sfs_host_model.xfer(1'b0, c, 16'h0000, r);
        chk(r, {2'b10, e});
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        u_sfs_host_model.xfer(1'b1, c, d, r);
        chk(r, {2'b10, 16'h0000});
    endtask
    task automatic bad(input logic w, input logic [7:0] c);
        u_sfs_host_model.xfer(w, c, 16'h0000, r);
        chk(r, {2'b11, 16'h0000});
    endtask
    // one sample strobe; 0 input, 1 output voltage, 2 current; flag lands two edges later
    task automatic meas(input int k, input logic [11:0] c);
        @(posedge mclk_i);
        vin_valid_i  <= (k == 0);
        output_sense_pin_valid_i <= (k == 1);
        iout_valid_i <= (k == 2);
        vin_code_i   <= c;
        output_sense_pin_code_i  <= c;
        iout_code_i  <= c;
        @(posedge mclk_i);
        vin_valid_i  <= 1'b0;
        output_sense_pin_valid_i <= 1'b0;
        iout_valid_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask

    initial begin
        #200us;
        mismatches++;
        $display("Error at %0t: run timed out", $time);
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(sfs_pkg::CMD_SUMMARY, 16'h0000);
        rd(sfs_pkg::CMD_OUT_VOLT, 16'h0000);
        chk({rsp_valid_b, rsp_err_b, rsp_data_b}, {2'b11, 16'h0000});
        rd(sfs_pkg::CMD_OUT_CURR, 16'h0000);
        rd(sfs_pkg::CMD_IN_SUPPLY, 16'h0000);
        rd(sfs_pkg::CMD_VIN_HI_LIM, 16'h0fff);
        rd(sfs_pkg::CMD_CUR_LIM, 16'h0fff);
        @(posedge mclk_i) gate_off_i <= 1'b1;
        rd(sfs_pkg::CMD_STATUS_BYTE, 16'h0040);
        rd(sfs_pkg::CMD_SUMMARY, 16'h0040);
        @(posedge mclk_i) gate_off_i <= 1'b0;
        $display("test reset done");
        // equal codes must not trip the strict comparisons
        wr(sfs_pkg::CMD_OUTPUT_SENSE_PIN_HI_LIM, 16'h0100);
        wr(sfs_pkg::CMD_OUTPUT_SENSE_PIN_LO_LIM, 16'h0080);
        rd(sfs_pkg::CMD_OUTPUT_SENSE_PIN_LO_LIM, 16'h0080);
        meas(1, 12'h100);
        meas(1, 12'h080);
        rd(sfs_pkg::CMD_OUT_VOLT, 16'h0000);
        meas(1, 12'h101);
        rd(sfs_pkg::CMD_OUT_VOLT, 16'h0040);
        meas(1, 12'h07f);
        rd(sfs_pkg::CMD_OUT_VOLT, 16'h0060);
        rd(sfs_pkg::CMD_SUMMARY, 16'h8001);
        // variant without output sense never raises the voltage flags; only its command error shows
        chk({rsp_valid_b, rsp_err_b, rsp_data_b}, {2'b10, 16'h0002});
        $display("test output voltage done");
        wr(sfs_pkg::CMD_CUR_LIM, 16'h0200);
        meas(2, 12'h200);
        rd(sfs_pkg::CMD_OUT_CURR, 16'h0000);
        meas(2, 12'h201);
        rd(sfs_pkg::CMD_OUT_CURR, 16'h0020);
        @(posedge mclk_i) current_trip_fault_i <= 1'b1;
        @(posedge mclk_i) current_trip_fault_i <= 1'b0;
        rd(sfs_pkg::CMD_OUT_CURR, 16'h00a0);
        rd(sfs_pkg::CMD_SUMMARY, 16'hc011);
        $display("test current done");
        wr(sfs_pkg::CMD_VIN_HI_LIM, 16'h0300);
        wr(sfs_pkg::CMD_VIN_LO_LIM, 16'h0010);
        meas(0, 12'h301);
        meas(0, 12'h00f);
        rd(sfs_pkg::CMD_IN_SUPPLY, 16'h0060);
        @(posedge mclk_i);
        high_limit_input_pin_i <= 1'b1;
        low_limit_input_pin_i  <= 1'b1;
        foldback_sense_pin_i   <= 1'b0;
        vendor_flags_byte_i    <= 8'h01;
        repeat (8) @(posedge mclk_i);
        rd(sfs_pkg::CMD_SUMMARY, 16'hf819);
        chk({17'h0_0000, supply_good_pin_o}, 18'h0_0000);
        @(posedge mclk_i);
        high_limit_input_pin_i <= 1'b0;
        low_limit_input_pin_i  <= 1'b0;
        foldback_sense_pin_i   <= 1'b1;
        vendor_flags_byte_i    <= 8'h00;
        repeat (8) @(posedge mclk_i);
        chk({17'h0_0000, supply_good_pin_o}, 18'h0_0001);
        // causes gone, latches must hold
        rd(sfs_pkg::CMD_IN_SUPPLY, 16'h00f0);
        rd(sfs_pkg::CMD_SUMMARY, 16'he019);
        $display("test input supply done");
        bad(1'b0, 8'h00);
        bad(1'b1, sfs_pkg::CMD_SUMMARY);
        rd(sfs_pkg::CMD_STATUS_BYTE, 16'h001b);
        wr(sfs_pkg::CMD_CLEAR, 16'h0000);
        rd(sfs_pkg::CMD_SUMMARY, 16'h0000);
        rd(sfs_pkg::CMD_OUT_VOLT, 16'h0000);
        rd(sfs_pkg::CMD_OUT_CURR, 16'h0000);
        rd(sfs_pkg::CMD_IN_SUPPLY, 16'h0000);
        $display("test errors and clear done");
        print_verdict();
    end
endmodule // sfs_status_regs_test
